// ===== pkg/emcs_pkg.sv
// Shared constants, types and CRC step for the memory command sequencer
package emcs_pkg;
  localparam logic [7:0] CMD_READ_STATUS = 8'haa;
  localparam logic [7:0] CMD_EXT_READ = 8'ha5;
  localparam logic [7:0] CMD_WRITE_MEM = 8'h0f;
  localparam logic [7:0] CMD_SPEED_WRITE = 8'hf3;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_CLEAR = 16'h0000;
  localparam logic [15:0] DATA_MASK = 16'h07ff;
  localparam logic [15:0] DATA_LAST = 16'h07ff;
  localparam logic [15:0] STATUS_LAST = 16'h013f;
  localparam logic [8:0] REDIR_BASE = 9'h100;
  localparam logic [2:0] STATUS_PAGE_END = 3'h7;
  localparam logic [4:0] DATA_PAGE_END = 5'h1f;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] NOT_REDIRECTED = 8'hff;
  localparam logic [3:0] BYTE_END = 4'h7;
  localparam logic [3:0] CRC_END = 4'hf;
  localparam logic [3:0] HI_KEEP_BITS = 4'h3;
  localparam int DATA_BYTES = 2048;
  localparam int STATUS_BYTES = 320;
  localparam int PROG_TIME_US = 480;
  localparam int CLOCK_MHZ = 100;
  localparam int PROG_CYCLES = PROG_TIME_US * CLOCK_MHZ;
  localparam logic [1:0] SK_DATA = 2'h0;
  localparam logic [1:0] SK_REDIR = 2'h1;
  localparam logic [1:0] SK_VERIFY = 2'h2;
  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_WRITE_BYTE = 3'h1,
    OP_READ_BYTE = 3'h2,
    OP_READ_CRC = 3'h3,
    OP_LOAD_CRC = 3'h4,
    OP_PROG = 3'h5,
    OP_VERIFY = 3'h6
  } emcs_op_t;
  function automatic logic [15:0] emcs_crc_step(input logic [15:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    emcs_crc_step = {1'b0, crc[15:1]} ^ (fb ? CRC_POLY : CRC_CLEAR);
  endfunction
endpackage

// ===== pkg/emcs_link_if.sv
// Slot-level link between bus master and memory device
`timescale 1ns/1ps
interface emcs_link_if;
  logic bus_reset;
  logic prog_pulse;
  logic slot_valid;
  logic slot_ready;
  logic slot_write;
  logic slot_bit;
  logic ans_valid;
  logic ans_ready;
  logic ans_bit;
  modport device(input bus_reset, input prog_pulse, input slot_valid, input slot_write, input slot_bit,
    input ans_ready, output slot_ready, output ans_valid, output ans_bit);
  modport master(output bus_reset, output prog_pulse, output slot_valid, output slot_write, output slot_bit,
    output ans_ready, input slot_ready, input ans_valid, input ans_bit);
endinterface

// ===== verilog/emcs_device.sv
// Device end: memory command sequencer with EPROM arrays
// Behaviour
// - First status page CRC covers command, address, data
// - Status page ends at low nibble 7/F
// - Later status pages: cleared CRC, data only
// - After last status CRC answer ones
// - Bus reset abandons any command
// - A5h then low, high address byte
// - Redirection byte then CRC incl. command, address
// - Master treats FFh as not redirected
// - Data to page end, then data-only CRC
// - Next page: redirection byte, its CRC, data
// - After last data page CRC answer ones
// - 0Fh, address, data byte, then CRC
// - Write address above 07FFh masked to 11
// - Programming pulse only clears bits
// - Verify slots return stored byte LSB first
// - After verify: address+1, preload CRC
// - Next data byte shifted into preloaded CRC
// - Master resets and sets VERIFY_FAIL_OUT on verify failure
// - Master resets on wrong CRC
// - F3h skips CRC before programming pulse
// - Speed write only with firm contact
// - All transfers least significant bit first
// - AAh reads status to 8-byte page end
`timescale 1ns/1ps
module emcs_device (
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  emcs_link_if.device link,
  input wire logic STATUS_WR_EN_IN,
  input wire logic [8:0] STATUS_WR_ADDR_IN,
  input wire logic [7:0] STATUS_WR_DATA_IN,
  output logic [7:0] CMD_OUT,
  output logic BUSY_OUT
);
  typedef enum logic [7:0] {
    DS_CMD = 8'h01,
    DS_ADDR_LO = 8'h02,
    DS_ADDR_HI = 8'h04,
    DS_WDATA = 8'h08,
    DS_SEND = 8'h10,
    DS_CRC = 8'h20,
    DS_PROG = 8'h40,
    DS_ONES = 8'h80
  } emcs_dev_state_t;

  emcs_dev_state_t state_q, state_d;
  logic [7:0] cmd_q, cmd_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] wdata_q, wdata_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [15:0] crc_q, crc_d;
  logic [1:0] kind_q, kind_d;
  logic redir_crc_q, redir_crc_d;
  logic prog_prev_q;
  logic head_v_q, head_v_d, head_b_q, head_b_d;
  logic tail_v_q, tail_v_d, tail_b_q, tail_b_d;
  logic room_q, room_d;
  logic busy_q, busy_d;
  logic [7:0] data_mem [0:emcs_pkg::DATA_BYTES-1];
  logic [7:0] status_mem [0:emcs_pkg::STATUS_BYTES-1];
  logic rd_slot, wr_slot, push, pop, out_bit, in_bit, prog_wr, is_write;
  logic [7:0] cur_byte, in_byte;
  logic [8:0] redir_idx;
  logic [15:0] addr_inc, hi_addr;

  // Room flag is kept as a flop so ready leaves with no gate after it
  assign link.slot_ready = room_q;
  assign link.ans_valid = head_v_q;
  assign link.ans_bit = head_b_q;
  assign CMD_OUT = cmd_q;
  assign BUSY_OUT = busy_q;

  always_comb begin
    rd_slot = link.slot_valid && room_q && !link.slot_write;
    wr_slot = link.slot_valid && room_q && link.slot_write;
    is_write = (cmd_q == emcs_pkg::CMD_WRITE_MEM) || (cmd_q == emcs_pkg::CMD_SPEED_WRITE);
    addr_inc = addr_q + 16'h0001;
    redir_idx = emcs_pkg::REDIR_BASE + {3'h0, addr_q[10:5]};
    // Unimplemented status space reads erased
    if (kind_q == emcs_pkg::SK_REDIR) begin
      cur_byte = status_mem[redir_idx];
    end else if (kind_q == emcs_pkg::SK_DATA && cmd_q == emcs_pkg::CMD_READ_STATUS) begin
      cur_byte = (addr_q <= emcs_pkg::STATUS_LAST) ? status_mem[addr_q[8:0]] : emcs_pkg::ERASED;
    end else begin
      cur_byte = data_mem[addr_q[10:0]];
    end
    case (state_q)
      DS_SEND: out_bit = cur_byte[bitcnt_q[2:0]];
      DS_CRC: out_bit = crc_q[bitcnt_q];
      default: out_bit = 1'b1;
    endcase
    // Upper five address bits of a write are forced low as they arrive
    in_bit = link.slot_bit;
    if (state_q == DS_ADDR_HI && is_write && bitcnt_q >= emcs_pkg::HI_KEEP_BITS) begin
      in_bit = 1'b0;
    end
    in_byte = {in_bit, shift_q[7:1]};
    hi_addr = {in_byte, addr_q[7:0]};
    push = rd_slot;
    pop = head_v_q && link.ans_ready;
    prog_wr = 1'b0;
    state_d = state_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    shift_d = shift_q;
    wdata_d = wdata_q;
    bitcnt_d = bitcnt_q;
    crc_d = crc_q;
    kind_d = kind_q;
    redir_crc_d = redir_crc_q;
    case (state_q)
      DS_CMD, DS_ADDR_LO, DS_ADDR_HI, DS_WDATA: begin
        if (wr_slot) begin
          shift_d = in_byte;
          crc_d = emcs_pkg::emcs_crc_step(crc_q, in_bit);
          bitcnt_d = bitcnt_q + 4'h1;
          if (bitcnt_q == emcs_pkg::BYTE_END) begin
            bitcnt_d = 4'h0;
            case (state_q)
              DS_CMD: begin
                cmd_d = in_byte;
                if (in_byte == emcs_pkg::CMD_READ_STATUS || in_byte == emcs_pkg::CMD_EXT_READ ||
                    in_byte == emcs_pkg::CMD_WRITE_MEM || in_byte == emcs_pkg::CMD_SPEED_WRITE) begin
                  state_d = DS_ADDR_LO;
                end else begin
                  state_d = DS_ONES;
                end
              end
              DS_ADDR_LO: begin
                addr_d = {8'h00, in_byte};
                state_d = DS_ADDR_HI;
              end
              DS_ADDR_HI: begin
                kind_d = emcs_pkg::SK_DATA;
                if (cmd_q == emcs_pkg::CMD_READ_STATUS) begin
                  addr_d = hi_addr;
                  state_d = DS_SEND;
                end else if (cmd_q == emcs_pkg::CMD_EXT_READ) begin
                  addr_d = hi_addr & emcs_pkg::DATA_MASK;
                  kind_d = emcs_pkg::SK_REDIR;
                  state_d = DS_SEND;
                end else begin
                  addr_d = hi_addr;
                  state_d = DS_WDATA;
                end
              end
              default: begin
                wdata_d = in_byte;
                // Speed write goes straight to the programming wait
                state_d = (cmd_q == emcs_pkg::CMD_SPEED_WRITE) ? DS_PROG : DS_CRC;
              end
            endcase
          end
        end
      end
      DS_SEND: begin
        if (rd_slot) begin
          if (kind_q != emcs_pkg::SK_VERIFY) begin
            crc_d = emcs_pkg::emcs_crc_step(crc_q, out_bit);
          end
          bitcnt_d = bitcnt_q + 4'h1;
          if (bitcnt_q == emcs_pkg::BYTE_END) begin
            bitcnt_d = 4'h0;
            if (kind_q == emcs_pkg::SK_REDIR) begin
              redir_crc_d = 1'b1;
              state_d = DS_CRC;
            end else if (kind_q == emcs_pkg::SK_VERIFY) begin
              // Address moves on whatever the verify byte showed
              addr_d = addr_inc & emcs_pkg::DATA_MASK;
              crc_d = addr_inc & emcs_pkg::DATA_MASK;
              state_d = DS_WDATA;
            end else if (cmd_q == emcs_pkg::CMD_READ_STATUS ? addr_q[2:0] == emcs_pkg::STATUS_PAGE_END :
                         addr_q[4:0] == emcs_pkg::DATA_PAGE_END) begin
              redir_crc_d = 1'b0;
              state_d = DS_CRC;
            end else begin
              addr_d = addr_inc;
            end
          end
        end
      end
      DS_CRC: begin
        if (rd_slot) begin
          bitcnt_d = bitcnt_q + 4'h1;
          if (bitcnt_q == emcs_pkg::CRC_END) begin
            bitcnt_d = 4'h0;
            kind_d = emcs_pkg::SK_DATA;
            if (is_write) begin
              state_d = DS_PROG;
            end else if (redir_crc_q) begin
              crc_d = emcs_pkg::CRC_CLEAR;
              state_d = DS_SEND;
            end else if (addr_q >= (cmd_q == emcs_pkg::CMD_READ_STATUS ? emcs_pkg::STATUS_LAST :
                                    emcs_pkg::DATA_LAST)) begin
              state_d = DS_ONES;
            end else begin
              crc_d = emcs_pkg::CRC_CLEAR;
              addr_d = addr_inc;
              if (cmd_q == emcs_pkg::CMD_EXT_READ) begin
                kind_d = emcs_pkg::SK_REDIR;
              end
              state_d = DS_SEND;
            end
          end
        end
      end
      DS_PROG: begin
        // Programming takes effect when the pulse ends
        if (prog_prev_q && !link.prog_pulse) begin
          prog_wr = 1'b1;
          kind_d = emcs_pkg::SK_VERIFY;
          bitcnt_d = 4'h0;
          state_d = DS_SEND;
        end
      end
      DS_ONES: state_d = DS_ONES;
      default: state_d = DS_CMD;
    endcase
    head_v_d = head_v_q;
    head_b_d = head_b_q;
    tail_v_d = tail_v_q;
    tail_b_d = tail_b_q;
    if (pop) begin
      head_v_d = tail_v_q;
      head_b_d = tail_b_q;
      tail_v_d = 1'b0;
    end
    if (push && !head_v_d) begin
      head_v_d = 1'b1;
      head_b_d = out_bit;
    end else if (push) begin
      tail_v_d = 1'b1;
      tail_b_d = out_bit;
    end
    if (link.bus_reset) begin
      state_d = DS_CMD;
      crc_d = emcs_pkg::CRC_CLEAR;
      bitcnt_d = 4'h0;
      prog_wr = 1'b0;
      head_v_d = 1'b0;
      tail_v_d = 1'b0;
    end
    room_d = !(head_v_d && tail_v_d);
    busy_d = state_d != DS_CMD;
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      state_q <= DS_CMD;
      cmd_q <= 8'h00;
      addr_q <= 16'h0000;
      shift_q <= 8'h00;
      wdata_q <= 8'hff;
      bitcnt_q <= 4'h0;
      crc_q <= emcs_pkg::CRC_CLEAR;
      kind_q <= emcs_pkg::SK_DATA;
      redir_crc_q <= 1'b0;
      prog_prev_q <= 1'b0;
      head_v_q <= 1'b0;
      head_b_q <= 1'b0;
      tail_v_q <= 1'b0;
      tail_b_q <= 1'b0;
      room_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      shift_q <= shift_d;
      wdata_q <= wdata_d;
      bitcnt_q <= bitcnt_d;
      crc_q <= crc_d;
      kind_q <= kind_d;
      redir_crc_q <= redir_crc_d;
      prog_prev_q <= link.prog_pulse;
      head_v_q <= head_v_d;
      head_b_q <= head_b_d;
      tail_v_q <= tail_v_d;
      tail_b_q <= tail_b_d;
      room_q <= room_d;
      busy_q <= busy_d;
    end
  end

  // Chip reset models an erased part; bus reset never touches the arrays
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < emcs_pkg::DATA_BYTES; i++) begin
        data_mem[i] <= emcs_pkg::ERASED;
      end
      for (int i = 0; i < emcs_pkg::STATUS_BYTES; i++) begin
        status_mem[i] <= emcs_pkg::ERASED;
      end
    end else begin
      if (prog_wr) begin
        data_mem[addr_q[10:0]] <= data_mem[addr_q[10:0]] & wdata_q;
      end
      if (STATUS_WR_EN_IN && STATUS_WR_ADDR_IN <= emcs_pkg::STATUS_LAST[8:0]) begin
        status_mem[STATUS_WR_ADDR_IN] <= status_mem[STATUS_WR_ADDR_IN] & STATUS_WR_DATA_IN;
      end
    end
  end
endmodule

// ===== verilog/emcs_master.sv
// Master end: byte-level operations turned into link slots
`timescale 1ns/1ps
module emcs_master #(
  parameter int PROG_CYCLES = emcs_pkg::PROG_CYCLES
) (
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  emcs_link_if.master link,
  input wire logic OP_VALID_IN,
  input wire logic [2:0] OP_CODE_IN,
  input wire logic [15:0] OP_DATA_IN,
  output logic OP_READY_OUT,
  output logic DONE_OUT,
  output logic [15:0] RESULT_OUT,
  output logic CRC_OK_OUT,
  output logic REDIRECTED_OUT,
  output logic [15:0] REDIRECT_ADDR_OUT,
  output logic VERIFY_FAIL_OUT
);
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_SLOT = 5'h02,
    HS_WAIT = 5'h04,
    HS_PROG = 5'h08,
    HS_DONE = 5'h10
  } emcs_host_state_t;

  emcs_host_state_t state_q, state_d;
  emcs_pkg::emcs_op_t op_q, op_d;
  logic [15:0] data_q, data_d, rx_q, rx_d, crc_q, crc_d, res_q, res_d, raddr_q, raddr_d;
  logic [3:0] cnt_q, cnt_d, last_q, last_d;
  logic [15:0] pcnt_q, pcnt_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic sv_q, sv_d, sw_q, sw_d, sb_q, sb_d, ar_q, ar_d, rst_q, rst_d, prog_q, prog_d;
  logic ok_q, ok_d, redir_q, redir_d, vf_q, vf_d, rdy_q, rdy_d, done_q, done_d;

  assign link.slot_valid = sv_q;
  assign link.slot_write = sw_q;
  assign link.slot_bit = sb_q;
  assign link.ans_ready = ar_q;
  assign link.bus_reset = rst_q;
  assign link.prog_pulse = prog_q;
  assign OP_READY_OUT = rdy_q;
  assign DONE_OUT = done_q;
  assign RESULT_OUT = res_q;
  assign CRC_OK_OUT = ok_q;
  assign REDIRECTED_OUT = redir_q;
  assign REDIRECT_ADDR_OUT = raddr_q;
  assign VERIFY_FAIL_OUT = vf_q;

  always_comb begin
    // Enum state kept out of the vector copy so it stays typed
    state_d = state_q;
    op_d = op_q;
    {data_d, rx_d, crc_d, res_d, raddr_d} = {data_q, rx_q, crc_q, res_q, raddr_q};
    {cnt_d, last_d, pcnt_d, wbyte_d} = {cnt_q, last_q, pcnt_q, wbyte_q};
    {sv_d, sw_d, sb_d, ar_d, prog_d, ok_d, redir_d, vf_d} = {sv_q, sw_q, sb_q, ar_q, prog_q, ok_q, redir_q, vf_q};
    rst_d = 1'b0;
    rdy_d = rdy_q;
    done_d = 1'b0;
    case (state_q)
      HS_IDLE: begin
        if (OP_VALID_IN && rdy_q) begin
          rdy_d = 1'b0;
          op_d = emcs_pkg::emcs_op_t'(OP_CODE_IN);
          data_d = OP_DATA_IN;
          cnt_d = 4'h0;
          last_d = (OP_CODE_IN == emcs_pkg::OP_READ_CRC) ? emcs_pkg::CRC_END : emcs_pkg::BYTE_END;
          state_d = HS_DONE;
          case (emcs_pkg::emcs_op_t'(OP_CODE_IN))
            emcs_pkg::OP_RESET: begin
              rst_d = 1'b1;
              ok_d = 1'b0;
              crc_d = emcs_pkg::CRC_CLEAR;
            end
            emcs_pkg::OP_LOAD_CRC: crc_d = OP_DATA_IN;
            emcs_pkg::OP_WRITE_BYTE: begin
              wbyte_d = OP_DATA_IN[7:0];
              {sv_d, sw_d, sb_d} = {1'b1, 1'b1, OP_DATA_IN[0]};
              state_d = HS_SLOT;
            end
            emcs_pkg::OP_PROG: begin
              // Bit 0 of the data marks a speed write with no CRC read
              if (ok_q || OP_DATA_IN[0]) begin
                prog_d = 1'b1;
                pcnt_d = 16'h0000;
                state_d = HS_PROG;
              end else begin
                rst_d = 1'b1;
              end
            end
            emcs_pkg::OP_READ_BYTE, emcs_pkg::OP_READ_CRC, emcs_pkg::OP_VERIFY: begin
              {sv_d, sw_d, sb_d} = {1'b1, 1'b0, 1'b1};
              state_d = HS_SLOT;
            end
            default: state_d = HS_DONE;
          endcase
        end
      end
      HS_SLOT: begin
        if (link.slot_ready) begin
          sv_d = 1'b0;
          if (sw_q) begin
            crc_d = emcs_pkg::emcs_crc_step(crc_q, sb_q);
            if (cnt_q == last_q) begin
              state_d = HS_DONE;
            end else begin
              cnt_d = cnt_q + 4'h1;
              sv_d = 1'b1;
              sb_d = data_q[cnt_q + 4'h1];
            end
          end else begin
            ar_d = 1'b1;
            state_d = HS_WAIT;
          end
        end
      end
      HS_WAIT: begin
        if (link.ans_valid) begin
          ar_d = 1'b0;
          rx_d = {link.ans_bit, rx_q[15:1]};
          if (op_q == emcs_pkg::OP_READ_BYTE) begin
            crc_d = emcs_pkg::emcs_crc_step(crc_q, link.ans_bit);
          end
          if (cnt_q != last_q) begin
            cnt_d = cnt_q + 4'h1;
            {sv_d, sw_d, sb_d} = {1'b1, 1'b0, 1'b1};
            state_d = HS_SLOT;
          end else begin
            state_d = HS_DONE;
            res_d = rx_d;
            if (op_q == emcs_pkg::OP_READ_CRC) begin
              ok_d = (rx_d == crc_q);
              rst_d = (rx_d != crc_q);
              crc_d = emcs_pkg::CRC_CLEAR;
            end else begin
              res_d = {8'h00, rx_d[15:8]};
              redir_d = rx_d[15:8] != emcs_pkg::NOT_REDIRECTED;
              raddr_d = {3'h0, ~rx_d[15:8], 5'h00};
              if (op_q == emcs_pkg::OP_VERIFY) begin
                vf_d = |(rx_d[15:8] & ~wbyte_q);
                rst_d = |(rx_d[15:8] & ~wbyte_q);
              end
            end
          end
        end
      end
      HS_PROG: begin
        pcnt_d = pcnt_q + 16'h0001;
        if (pcnt_q == 16'(PROG_CYCLES - 1)) begin
          prog_d = 1'b0;
          ok_d = 1'b0;
          state_d = HS_DONE;
        end
      end
      HS_DONE: begin
        done_d = 1'b1;
        rdy_d = 1'b1;
        state_d = HS_IDLE;
      end
      default: state_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      state_q <= HS_IDLE;
      op_q <= emcs_pkg::OP_RESET;
      {data_q, rx_q, crc_q, res_q, raddr_q, pcnt_q} <= {6{16'h0000}};
      {cnt_q, last_q, wbyte_q} <= 16'h0000;
      {sv_q, sw_q, sb_q, ar_q, rst_q, prog_q, ok_q, redir_q, vf_q, done_q} <= 10'h000;
      rdy_q <= 1'b1;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      {data_q, rx_q, crc_q, res_q, raddr_q} <= {data_d, rx_d, crc_d, res_d, raddr_d};
      {cnt_q, last_q, pcnt_q, wbyte_q} <= {cnt_d, last_d, pcnt_d, wbyte_d};
      {sv_q, sw_q, sb_q, ar_q, rst_q, prog_q} <= {sv_d, sw_d, sb_d, ar_d, rst_d, prog_d};
      {ok_q, redir_q, vf_q, rdy_q, done_q} <= {ok_d, redir_d, vf_d, rdy_d, done_d};
    end
  end
endmodule

// ===== bench/emcs_link_sva.sv
// Link protocol assertions between master and device ends
`timescale 1ns/1ps
module emcs_link_sva #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic bus_reset,
  input wire logic prog_pulse,
  input wire logic slot_valid,
  input wire logic slot_ready,
  input wire logic slot_write,
  input wire logic slot_bit,
  input wire logic ans_valid,
  input wire logic ans_ready,
  input wire logic ans_bit
);
  logic [1:0] pend_q;
  logic [1:0] pend_d;
  logic [31:0] hi_q;
  logic [31:0] hi_d;
  // Read slots not yet answered; bus reset drops them with the buffer
  always_comb begin
    pend_d = pend_q + {1'b0, slot_valid & slot_ready & ~slot_write} - {1'b0, ans_valid & ans_ready};
    if (bus_reset) begin
      pend_d = 2'h0;
    end
    hi_d = prog_pulse ? hi_q + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      pend_q <= 2'h0;
      hi_q <= 32'h0000_0000;
    end else begin
      pend_q <= pend_d;
      hi_q <= hi_d;
    end
  end
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  a_slot_hold: assert property (slot_valid && !slot_ready |=> slot_valid && $stable(slot_write) && $stable(slot_bit))
    else $error("slot changed before taken");
  a_ans_hold: assert property (ans_valid && !ans_ready && !bus_reset |=> ans_valid && $stable(ans_bit))
    else $error("answer changed before taken");
  a_reset_flush: assert property (bus_reset |=> !ans_valid)
    else $error("answer survived bus reset");
  a_reset_pulse: assert property (bus_reset |=> !bus_reset)
    else $error("bus reset longer than one cycle");
  a_prog_length: assert property ($fell(prog_pulse) |-> hi_q == 32'(PROG_CYCLES))
    else $error("programming pulse length wrong");
  a_prog_quiet: assert property (prog_pulse |-> !slot_valid && !bus_reset)
    else $error("slot or reset during programming");
  a_ans_cause: assert property (ans_valid |-> pend_q != 2'h0)
    else $error("answer without read slot");
  a_pend_bound: assert property (pend_q != 2'h3)
    else $error("more than two answers pending");
  a_ans_prompt: assert property (slot_valid && slot_ready && !slot_write && pend_q == 2'h0 && !bus_reset |=> ans_valid)
    else $error("read slot not answered next cycle");
endmodule

// ===== bench/eprom_memory_command_sequencer_tb_top.sv
// Top bench: master and device joined over the slot link
`timescale 1ns/1ps
module eprom_memory_command_sequencer_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [15:0] op_data = 16'h0000;
  logic sw_en = 1'b0;
  logic [8:0] sw_addr = 9'h000;
  logic [7:0] sw_data = 8'h00;
  logic op_ready, done, crc_ok, redir, vfail, busy;
  logic [15:0] result, redir_addr, a, c;
  logic [7:0] b, r, cmd, cmd_seen;
  logic [31:0] lfsr = 32'hefac_1321;
  logic [7:0] dmem [2048];
  logic [7:0] smem [64];
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  emcs_link_if link ();
  emcs_master #(.PROG_CYCLES(20)) i_emcs_master (.CLOCK_IN(clk), .RESET_IN(rst), .link(link), .OP_VALID_IN(op_valid),
    .OP_CODE_IN(op_code), .OP_DATA_IN(op_data), .OP_READY_OUT(op_ready), .DONE_OUT(done), .RESULT_OUT(result),
    .CRC_OK_OUT(crc_ok), .REDIRECTED_OUT(redir), .REDIRECT_ADDR_OUT(redir_addr), .VERIFY_FAIL_OUT(vfail));
  emcs_device i_emcs_device (.CLOCK_IN(clk), .RESET_IN(rst), .link(link), .STATUS_WR_EN_IN(sw_en),
    .STATUS_WR_ADDR_IN(sw_addr), .STATUS_WR_DATA_IN(sw_data), .CMD_OUT(cmd_seen), .BUSY_OUT(busy));
  emcs_link_sva #(.PROG_CYCLES(20)) i_emcs_link_sva (.CLOCK_IN(clk), .RESET_IN(rst), .bus_reset(link.bus_reset),
    .prog_pulse(link.prog_pulse), .slot_valid(link.slot_valid), .slot_ready(link.slot_ready),
    .slot_write(link.slot_write), .slot_bit(link.slot_bit), .ans_valid(link.ans_valid),
    .ans_ready(link.ans_ready), .ans_bit(link.ans_bit));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Generous ceiling; a full run needs under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end
  function automatic logic [15:0] crcb(input logic [15:0] v, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, v[15:1]} ^ ((v[0] ^ d[i]) ? 16'ha001 : 16'h0000);
    end
    return v;
  endfunction
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // Called just after an edge; returns just after the done edge
  task automatic op(input logic [2:0] cd, input logic [15:0] d);
    op_code = cd;
    op_data = d;
    op_valid = 1'b1;
    do @(posedge clk); while (op_ready !== 1'b1);
    #1 op_valid = 1'b0;
    do begin
      @(posedge clk);
      #1;
    end while (done !== 1'b1);
  endtask
  task automatic wb(input logic [7:0] d);
    op(emcs_pkg::OP_WRITE_BYTE, {8'h00, d});
    c = crcb(c, d);
  endtask
  task automatic rb(input logic [7:0] e);
    op(emcs_pkg::OP_READ_BYTE, 16'h0000);
    chk("byte", {8'h00, e}, {8'h00, result[7:0]});
    c = crcb(c, e);
  endtask
  task automatic rc();
    op(emcs_pkg::OP_READ_CRC, 16'h0000);
    chk("crc", c, result);
    chk("crc_ok", 16'h0001, {15'h0000, crc_ok});
    c = 16'h0000;
  endtask
  task automatic start(input logic [7:0] cm, input logic [15:0] ad);
    op(emcs_pkg::OP_RESET, 16'h0000);
    chk("busy_idle", 16'h0000, {15'h0000, busy});
    c = 16'h0000;
    wb(cm);
    chk("cmd", {8'h00, cm}, {8'h00, cmd_seen});
    wb(ad[7:0]);
    wb(ad[15:8]);
    chk("busy", 16'h0001, {15'h0000, busy});
  endtask
  initial begin
    for (int i = 0; i < 2048; i++) begin
      dmem[i] = 8'hff;
    end
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 64; i++) begin
      smem[i] = i[0] ? 8'hff : rnd();
      sw_en = 1'b1;
      sw_addr = 9'h100 + 9'(i);
      sw_data = smem[i];
      @(posedge clk);
      #1;
    end
    sw_en = 1'b0;
    b = rnd();
    a = 16'h07e0 | {12'h000, b[3:0]};
    // Second pass rewrites the same bytes at speed
    for (int k = 0; k < 2; k++) begin
      cmd = k[0] ? 8'hf3 : 8'h0f;
      start(cmd, a);
      for (int j = 0; j < 2; j++) begin
        if (j == 1) begin
          c = a + 16'h0001;
          op(emcs_pkg::OP_LOAD_CRC, c);
        end
        b = rnd();
        wb(b);
        if (k == 0) begin
          rc();
        end
        op(emcs_pkg::OP_PROG, {15'h0000, k[0]});
        dmem[a + 16'(j)] = dmem[a + 16'(j)] & b;
        op(emcs_pkg::OP_VERIFY, {8'h00, b});
        chk("verify", {8'h00, dmem[a + 16'(j)]}, {8'h00, result[7:0]});
        chk("vfail", {15'h0000, |(dmem[a + 16'(j)] & ~b)}, {15'h0000, vfail});
      end
    end
    b = rnd();
    start(8'h0f, {b | 8'hf8, 8'h10});
    c = crcb(crcb(crcb(16'h0000, 8'h0f), 8'h10), b & 8'h07);
    wb(b);
    op(emcs_pkg::OP_READ_CRC, 16'h0000);
    chk("crc_masked", c, result);
    chk("crc_ok_masked", 16'h0000, {15'h0000, crc_ok});
    // Unknown command: ones until the next bus reset
    start(8'h3c, 16'h0000);
    rb(8'hff);
    start(8'haa, 16'h0136);
    for (int ad = 16'h136; ad < 16'h140; ad++) begin
      rb(smem[ad - 256]);
      if (ad[2:0] == 3'h7) begin
        rc();
      end
    end
    rb(8'hff);
    start(8'ha5, 16'h07de);
    for (int ad = 16'h7de; ad < 16'h800; ad++) begin
      if (ad == 16'h7de || ad[4:0] == 5'h00) begin
        r = smem[ad >> 5];
        rb(r);
        chk("redir", {15'h0000, r != 8'hff}, {15'h0000, redir});
        chk("redir_addr", {3'h0, ~r, 5'h00}, redir_addr);
        rc();
      end
      rb(dmem[ad]);
      if (ad[4:0] == 5'h1f) begin
        rc();
      end
    end
    rb(8'hff);
    final_report();
  end
endmodule
